// ---- uspd_map.svh ----
// Address map, field positions and timing counts of the shadow data port
`ifndef USPD_MAP_SVH
`define USPD_MAP_SVH
`define USPD_DATA_ABS_ADDR 32'h5000_1138
`define USPD_WIN_SEL 2'h0
`define USPD_CTRL_ADDR 8'h40
`define USPD_LSR_ADDR 8'h44
`define USPD_IST_ADDR 8'h48
`define USPD_ICLR_ADDR 8'h4C
`define USPD_IEN_ADDR 8'h50
`define USPD_FIFO_DEPTH 5'h10
`define USPD_CTRL_FEN 0
`define USPD_CTRL_IR 1
`define USPD_CTRL_RESET 2'h0
`define USPD_LSR_DR 0
`define USPD_LSR_OE 1
`define USPD_LSR_TX_HOLDING_EMPTY_FLAG 5
`define USPD_LSR_TEMT 6
`define USPD_EV_RX 0
`define USPD_EV_OE 1
`define USPD_EV_TX_HOLDING_EMPTY_FLAG 2
`define USPD_EV_RESET 3'h0
`define USPD_DATA_RESET 8'h00
`define USPD_OVS_MID 4'h7
`define USPD_IR_MID 4'h0
`define USPD_OVS_LAST 4'hF
`define USPD_IR_PULSE 4'h3
`define USPD_BIT_LAST 3'h7
`endif

// ---- uspd_pkg.sv ----
// Types shared by the shadow data port
`default_nettype none
package uspd_pkg;
  typedef logic [7:0] uspd_byte_t; // One character
  typedef logic [7:0] uspd_addr_t; // Avalon byte address
  typedef logic [3:0] uspd_ptr_t; // FIFO slot index
  typedef logic [4:0] uspd_cnt_t; // FIFO fill level
  typedef enum logic [1:0] {USPD_IDLE, USPD_START, USPD_DATA, USPD_STOP} uspd_ser_e; // Serial frame phase
endpackage
`default_nettype wire

// ---- uspd_top.sv ----
// Shadow receive/transmit data port with FIFOs, serial/infrared line and Avalon-MM slave
`include "uspd_map.svh"
`default_nettype none
// Notes on behaviour
// - Received data valid only while data-ready set
// - No FIFO: new character overwrites, flags overrun
// - FIFO on: read returns oldest receive entry
// - Full receive FIFO keeps contents, drops, overruns
// - Sixteen aliased words reach one data path
// - Serial or infrared line chosen by mode
// - No FIFO: one write clears holding-empty
// - No FIFO: further writes overwrite pending character
// - FIFO on: sixteen writes accepted before full
// - Write to full transmit FIFO is dropped
module uspd_top (
  input wire logic clk_in, // 20 MHz bus clock
  input wire logic rst_n_in, // Async reset, active low
  input wire uspd_pkg::uspd_addr_t address_in, // Avalon byte address
  input wire logic read_in, // Avalon read
  input wire logic write_in, // Avalon write
  input wire logic [31:0] writedata_in, // Avalon write data
  input wire logic [3:0] byteenable_in, // Avalon byte enables
  output logic [31:0] readdata_out, // Avalon read data
  output logic waitrequest_out, // Avalon wait request
  input wire logic baud_tick_in, // 16x bit-rate tick, same clock
  input wire logic serial_in, // Plain serial receive pin
  input wire logic ir_in, // Infrared receive pin, high pulse is a zero
  output logic serial_out, // Plain serial transmit pin
  output logic ir_out_n_out, // Infrared transmit pin, active low
  output logic irq_out // Level interrupt
);
  import uspd_pkg::*;

  // Register state
  logic wait_r; // Wait request flop
  logic [31:0] readdata_r; // Captured read data
  logic [1:0] ctrl_r; // fifo_control: FIFO enable, infrared mode
  logic oe_r; // Sticky overrun in line_status
  logic [2:0] ist_r; // Interrupt status
  logic [2:0] ien_r; // Interrupt enable
  logic irq_r; // Interrupt output flop

  // Bump a FIFO slot index
  function automatic uspd_ptr_t ptr_inc(input uspd_ptr_t p);
    ptr_inc = p + 4'h1;
  endfunction

  // Bus decode
  wire fen = ctrl_r[`USPD_CTRL_FEN]; // FIFO mode
  wire ir_mode = ctrl_r[`USPD_CTRL_IR]; // Infrared mode
  wire acc = (read_in | write_in) & ~wait_r; // Access takes effect this edge
  // Read side effects land on the capture edge, so a character arriving before release is never popped unseen
  wire rd_take = read_in & wait_r; // Read data captured and consumed this edge
  wire data_hit = (address_in[7:6] == `USPD_WIN_SEL); // Any of sixteen aliases
  wire ctrl_hit = (address_in == `USPD_CTRL_ADDR);
  wire lsr_hit = (address_in == `USPD_LSR_ADDR);
  wire ist_hit = (address_in == `USPD_IST_ADDR);
  wire iclr_hit = (address_in == `USPD_ICLR_ADDR);
  wire ien_hit = (address_in == `USPD_IEN_ADDR);
  wire ctrl_wr = acc & write_in & ctrl_hit & byteenable_in[0];
  wire lsr_rd = rd_take & lsr_hit;
  wire fen_chg = ctrl_wr & (writedata_in[`USPD_CTRL_FEN] != fen); // Mode change flushes FIFOs

  // Receive line synchronisers
  logic ser_s1_r, ser_s2_r, irx_s1_r, irx_s2_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ser_s1_r <= 1'b1;
      ser_s2_r <= 1'b1;
      irx_s1_r <= 1'b0;
      irx_s2_r <= 1'b0;
    end else begin
      ser_s1_r <= serial_in;
      ser_s2_r <= ser_s1_r;
      irx_s1_r <= ir_in;
      irx_s2_r <= irx_s1_r;
    end
  end
  wire rx_line = ir_mode ? ~irx_s2_r : ser_s2_r;

  // Receive framer
  uspd_ser_e rx_st_r;
  logic [3:0] rx_ovs_r; // Oversample count
  logic [2:0] rx_bit_r; // Data bit index
  uspd_byte_t rx_shift_r; // Character being assembled
  wire rx_last = baud_tick_in & (rx_ovs_r == `USPD_OVS_LAST);
  wire rx_push = (rx_st_r == USPD_STOP) & rx_last & rx_line; // Good stop bit delivers a character
  // Infrared zeros are short pulses at the bit start, so that mode samples one tick after the edge, not mid-bit
  wire [3:0] rx_mid = ir_mode ? `USPD_IR_MID : `USPD_OVS_MID; // Start-bit confirm point
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_st_r <= USPD_IDLE;
      rx_ovs_r <= 4'h0;
      rx_bit_r <= 3'h0;
      rx_shift_r <= `USPD_DATA_RESET;
    end else if (baud_tick_in) begin
      rx_ovs_r <= rx_ovs_r + 4'h1;
      case (rx_st_r)
        // Wait for falling start edge
        USPD_IDLE: begin
          rx_ovs_r <= 4'h0;
          if (!rx_line) rx_st_r <= USPD_START;
        end
        // Confirm start at mid-bit, or one tick after the edge in infrared mode
        USPD_START: begin
          if (rx_ovs_r == rx_mid) begin
            rx_ovs_r <= 4'h0;
            rx_bit_r <= 3'h0;
            rx_st_r <= rx_line ? USPD_IDLE : USPD_DATA;
          end
        end
        // Sample data bits, LSB first
        USPD_DATA: begin
          if (rx_ovs_r == `USPD_OVS_LAST) begin
            rx_shift_r <= {rx_line, rx_shift_r[7:1]};
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == `USPD_BIT_LAST) rx_st_r <= USPD_STOP;
          end
        end
        // Stop bit ends the frame
        USPD_STOP: begin
          if (rx_ovs_r == `USPD_OVS_LAST) rx_st_r <= USPD_IDLE;
        end
        default: rx_st_r <= USPD_IDLE;
      endcase
    end
  end

  // Receive FIFO; with FIFOs off it is a single holding slot
  uspd_byte_t rx_mem_r [16];
  uspd_ptr_t rx_rd_r, rx_wr_r;
  uspd_cnt_t rx_cnt_r;
  wire rx_dr = (rx_cnt_r != 5'h00); // rx_data_valid_flag
  wire uspd_byte_t rx_head = rx_mem_r[rx_rd_r]; // Oldest character
  wire rx_pop = rd_take & data_hit & rx_dr;
  wire rx_room = (rx_cnt_r != `USPD_FIFO_DEPTH) | rx_pop;
  wire rx_wr_en = rx_push & fen & rx_room;
  wire ovr_ev = rx_push & (fen ? ~rx_room : (rx_dr & ~rx_pop));
  wire uspd_ptr_t rx_slot = fen ? rx_wr_r : rx_rd_r; // No FIFO: overwrite in place
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 16; i++) rx_mem_r[i] <= `USPD_DATA_RESET;
    end else if (rx_push & (~fen | rx_room)) begin
      rx_mem_r[rx_slot] <= rx_shift_r;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rx_rd_r <= 4'h0;
      rx_wr_r <= 4'h0;
      rx_cnt_r <= 5'h00;
    end else if (fen_chg) begin
      rx_rd_r <= 4'h0;
      rx_wr_r <= 4'h0;
      rx_cnt_r <= 5'h00;
    end else if (fen) begin
      if (rx_pop) rx_rd_r <= ptr_inc(rx_rd_r);
      if (rx_wr_en) rx_wr_r <= ptr_inc(rx_wr_r);
      rx_cnt_r <= rx_cnt_r + {4'h0, rx_wr_en} - {4'h0, rx_pop};
    end else begin
      rx_cnt_r <= rx_push ? 5'h01 : (rx_pop ? 5'h00 : rx_cnt_r);
      rx_wr_r <= rx_rd_r;
    end
  end

  // Transmit FIFO; with FIFOs off it is the holding register
  uspd_byte_t tx_mem_r [16];
  uspd_ptr_t tx_rd_r, tx_wr_r;
  uspd_cnt_t tx_cnt_r;
  uspd_ser_e tx_st_r;
  wire tx_holding_empty_flag = (tx_cnt_r == 5'h00); // tx_holding_empty_flag
  wire tx_wr = acc & write_in & data_hit & byteenable_in[0];
  wire tx_full = (tx_cnt_r == `USPD_FIFO_DEPTH);
  wire tx_pop = (tx_st_r == USPD_IDLE) & baud_tick_in & ~tx_holding_empty_flag; // Shifter takes next character
  wire tx_wr_ok = tx_wr & (~fen | ~tx_full);
  wire uspd_ptr_t tx_slot = fen ? tx_wr_r : tx_rd_r;
  wire uspd_cnt_t tx_cnt_nxt = fen ? (tx_cnt_r + {4'h0, tx_wr_ok} - {4'h0, tx_pop}) :
                                     (tx_wr ? 5'h01 : (tx_pop ? 5'h00 : tx_cnt_r));
  wire tx_holding_empty_flag_ev = ~tx_holding_empty_flag & (tx_cnt_nxt == 5'h00) & ~fen_chg;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 16; i++) tx_mem_r[i] <= `USPD_DATA_RESET;
    end else if (tx_wr_ok) begin
      tx_mem_r[tx_slot] <= writedata_in[7:0];
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_rd_r <= 4'h0;
      tx_wr_r <= 4'h0;
      tx_cnt_r <= 5'h00;
    end else if (fen_chg) begin
      tx_rd_r <= 4'h0;
      tx_wr_r <= 4'h0;
      tx_cnt_r <= 5'h00;
    end else begin
      tx_cnt_r <= tx_cnt_nxt;
      if (fen & tx_pop) tx_rd_r <= ptr_inc(tx_rd_r);
      tx_wr_r <= fen ? (tx_wr_ok ? ptr_inc(tx_wr_r) : tx_wr_r) : tx_rd_r;
    end
  end

  // Transmit framer
  logic [3:0] tx_ovs_r;
  logic [2:0] tx_bit_r;
  uspd_byte_t tx_shift_r;
  wire tx_last = baud_tick_in & (tx_ovs_r == `USPD_OVS_LAST);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_st_r <= USPD_IDLE;
      tx_ovs_r <= 4'h0;
      tx_bit_r <= 3'h0;
      tx_shift_r <= `USPD_DATA_RESET;
    end else begin
      if (baud_tick_in) tx_ovs_r <= tx_ovs_r + 4'h1;
      case (tx_st_r)
        // Load the oldest character
        USPD_IDLE: begin
          if (tx_pop) begin
            tx_shift_r <= tx_mem_r[tx_rd_r];
            tx_ovs_r <= 4'h0;
            tx_st_r <= USPD_START;
          end
        end
        // Start bit
        USPD_START: begin
          if (tx_last) begin
            tx_bit_r <= 3'h0;
            tx_st_r <= USPD_DATA;
          end
        end
        // Data bits, LSB first
        USPD_DATA: begin
          if (tx_last) begin
            tx_shift_r <= {1'b0, tx_shift_r[7:1]};
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == `USPD_BIT_LAST) tx_st_r <= USPD_STOP;
          end
        end
        // Stop bit
        USPD_STOP: begin
          if (tx_last) tx_st_r <= USPD_IDLE;
        end
        default: tx_st_r <= USPD_IDLE;
      endcase
    end
  end
  wire tx_level = (tx_st_r == USPD_START) ? 1'b0 : ((tx_st_r == USPD_DATA) ? tx_shift_r[0] : 1'b1);
  wire temt = tx_holding_empty_flag & (tx_st_r == USPD_IDLE);

  // Line pins: idle high; infrared sends a short low pulse per zero bit
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      serial_out <= 1'b1;
      ir_out_n_out <= 1'b1;
    end else begin
      serial_out <= ir_mode | tx_level;
      ir_out_n_out <= ~(ir_mode & ~tx_level & (tx_ovs_r < `USPD_IR_PULSE));
    end
  end

  // Status and interrupt sources
  wire [7:0] line_status = {1'b0, temt, tx_holding_empty_flag, 3'h0, oe_r, rx_dr};
  wire [2:0] ev = {tx_holding_empty_flag_ev, ovr_ev, rx_push};
  wire [2:0] iclr = (acc & write_in & iclr_hit & byteenable_in[0]) ? writedata_in[2:0] : 3'h0;
  wire [2:0] ist_nxt = ev | (ist_r & ~iclr); // Event wins over clear
  wire [31:0] rmux = data_hit ? {24'h0, rx_head} :
                     ctrl_hit ? {30'h0, ctrl_r} :
                     lsr_hit ? {24'h0, line_status} :
                     ist_hit ? {29'h0, ist_r} :
                     ien_hit ? {29'h0, ien_r} : 32'h0;

  // Control, status and interrupt registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= `USPD_CTRL_RESET;
      oe_r <= 1'b0;
      ist_r <= `USPD_EV_RESET;
      ien_r <= `USPD_EV_RESET;
      irq_r <= 1'b0;
    end else begin
      if (ctrl_wr) ctrl_r <= writedata_in[1:0];
      oe_r <= ovr_ev | (oe_r & ~lsr_rd);
      ist_r <= ist_nxt;
      if (acc & write_in & ien_hit & byteenable_in[0]) ien_r <= writedata_in[2:0];
      irq_r <= |(ist_nxt & ien_r);
    end
  end

  // Avalon handshake: one wait cycle, data captured at the request edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wait_r <= 1'b1;
      readdata_r <= 32'h0;
    end else begin
      wait_r <= ~((read_in | write_in) & wait_r);
      if (read_in & wait_r) readdata_r <= rmux;
    end
  end
  assign waitrequest_out = wait_r;
  assign readdata_out = readdata_r;
  assign irq_out = irq_r;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_rx_head_read: assert property ((read_in & wait_r & data_hit & rx_dr & fen) ##1 acc
    |-> readdata_out == {24'h0, $past(rx_head)}) else $error("data read not head");
  a_rx_dr_pop: assert property (rx_pop |-> ##1 (rx_cnt_r == $past(rx_cnt_r) - 5'h01 + {4'h0, $past(rx_wr_en)}
    || !$past(fen))) else $error("read did not drain data-ready");
  a_rx_nofifo_overwrite: assert property ((!fen & rx_push & !fen_chg) |=>
    (rx_cnt_r == 5'h01 && rx_head == $past(rx_shift_r) && oe_r == ($past(rx_dr & ~rx_pop) | $past(oe_r & ~lsr_rd))))
    else $error("no-fifo receive overwrite wrong");
  a_rx_full_drop: assert property ((fen & rx_push & !rx_room & !fen_chg) |=>
    (rx_cnt_r == `USPD_FIFO_DEPTH && oe_r && $stable(rx_wr_r) && $stable(rx_head)))
    else $error("full receive fifo not kept");
  a_alias_upper_zero: assert property ((read_in & wait_r & data_hit) |=>
    (readdata_out[31:8] == 24'h0 && !waitrequest_out)) else $error("alias read wrong");
  a_ir_line_idle: assert property ((ir_mode & !ctrl_wr) |=> serial_out)
    else $error("serial pin moved in infrared mode");
  a_tx_holding_empty_flag_clear: assert property ((!fen & tx_wr & !tx_pop & !fen_chg) |=> (!tx_holding_empty_flag ##1 1'b1))
    else $error("write did not clear holding-empty");
  a_tx_overwrite: assert property ((!fen & tx_wr & !tx_holding_empty_flag & !tx_pop & !fen_chg) |=>
    (tx_cnt_r == 5'h01 && tx_mem_r[tx_rd_r] == $past(writedata_in[7:0]))) else $error("holding not overwritten");
  a_tx_fill_count: assert property ((fen & tx_wr & !tx_full & !tx_pop & !fen_chg) |=>
    tx_cnt_r == $past(tx_cnt_r) + 5'h01) else $error("fifo write not counted");
  a_tx_full_drop: assert property ((fen & tx_wr & tx_full & !tx_pop & !fen_chg) |=>
    (tx_full && $stable(tx_wr_r))) else $error("write to full fifo not dropped");
  a_irq_level: assert property (($past(|(ist_nxt & ien_r))) |-> irq_out) else $error("interrupt missing");
  a_ir_pin_idle: assert property ((!ir_mode & !ctrl_wr) |=> ir_out_n_out)
    else $error("infrared pin moved in serial mode");
  a_rx_empty_read: assert property ((rd_take & data_hit & !rx_dr & !rx_push) |=>
    (rx_cnt_r == 5'h00 && $stable(rx_rd_r))) else $error("empty read changed receive state");
  // Covers for the main scenarios
  c_rx_overrun: cover property (fen & ovr_ev);
  c_tx_full: cover property (fen & tx_wr & tx_full);
  c_burst_alias: cover property ((acc & read_in & data_hit) ##3 (acc & read_in & data_hit));
  c_ir_receive: cover property (ir_mode & rx_push);
  c_tx_overwrite: cover property (!fen & tx_wr & !tx_holding_empty_flag);
endmodule
`default_nettype wire

// ---- uspd_far_dev.sv ----
// Remote serial/infrared character device facing the shadow data port
`default_nettype none
module uspd_far_dev (
  input wire logic clk_in, // Bus clock
  input wire logic baud_tick_in, // 16x bit-rate tick
  input wire logic ir_mode_in, // Talk over the infrared line
  input wire logic line_in, // Design serial output
  input wire logic ir_line_n_in, // Design infrared output, active low
  output logic serial_out, // Feeds design serial input
  output logic ir_out // Feeds design infrared input
);
  logic [7:0] rxq[$]; // Characters heard from the design
  logic [7:0] r; // Receive shift value
  logic s; // Current line sample
  // Idle levels: serial line pulled high, no infrared pulse
  initial begin
    serial_out = 1'b1;
    ir_out = 1'b0;
  end
  // Send one 8N1 frame, LSB first; an infrared zero is a 3-tick high pulse
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int t = 0; t < 16; t++) begin
        @(posedge clk_in iff baud_tick_in);
        serial_out <= ir_mode_in | f[i];
        ir_out <= ir_mode_in & ~f[i] & (t < 3);
      end
    end
  endtask
  // Decode frames: mid-bit sample on serial, inside the pulse on infrared
  always begin
    @(posedge clk_in iff (ir_mode_in ? !ir_line_n_in : !line_in));
    repeat (ir_mode_in ? 1 : 8) @(posedge clk_in iff baud_tick_in);
    for (int i = 0; i < 10; i++) begin
      s = ir_mode_in ? ir_line_n_in : line_in;
      // Data bits arrive LSB first
      if (i > 0 && i < 9) r = {s, r[7:1]};
      // Only a character with a good stop bit is kept
      if (i == 9 && s) rxq.push_back(r);
      if (i < 9) repeat (16) @(posedge clk_in iff baud_tick_in);
    end
  end
endmodule
`default_nettype wire

// ---- uspd_top_tb.sv ----
// Self-checking bench for the shadow data port
`include "uspd_map.svh"
`default_nettype none
module uspd_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import uspd_pkg::*;
  logic clk_in = 1'b0; // 20 MHz bus clock
  logic rst_n_in; // Reset, active low
  uspd_addr_t address_in; // Bus address
  logic read_in, write_in; // Bus strobes
  logic [31:0] writedata_in, readdata_out; // Bus data
  logic [3:0] byteenable_in; // Byte enables
  logic waitrequest_out, baud_tick_in, serial_in, ir_in; // Handshake, tick and line inputs
  logic serial_out, ir_out_n_out, irq_out, ir_mode; // Line outputs, interrupt, far-side mode
  logic [31:0] q; // Last read value
  int n_errors = 0; // Mismatches
  int checks = 0; // Comparisons made
  // Clock and a tick on every other cycle
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) baud_tick_in <= ~baud_tick_in;
  uspd_top uut (.clk_in, .rst_n_in, .address_in, .read_in, .write_in, .writedata_in, .byteenable_in,
    .readdata_out, .waitrequest_out, .baud_tick_in, .serial_in, .ir_in, .serial_out, .ir_out_n_out, .irq_out);
  uspd_far_dev u_far (.clk_in, .baud_tick_in, .ir_mode_in(ir_mode), .line_in(serial_out),
    .ir_line_n_in(ir_out_n_out), .serial_out(serial_in), .ir_out(ir_in));
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input uspd_addr_t a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    address_in <= a;
    writedata_in <= d;
    read_in <= ~wr;
    write_in <= wr;
    @(posedge clk_in);
    while (waitrequest_out !== 1'b0 && n < 20) begin
      n++;
      @(posedge clk_in);
    end
    if (n == 20) chk(0, 1, "no bus answer");
    r = readdata_out;
    read_in <= 1'b0;
    write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  // Read a register until a bit is set, bounded
  task automatic poll(input uspd_addr_t a, input int b);
    int n;
    q = 0;
    for (n = 0; n < 3000 && q[b] !== 1'b1; n++) bus(1'b0, a, 32'h0, q);
    chk(q[b], 1'b1, "flag wait");
  endtask
  // Wait until the far side has heard c characters
  task automatic wait_q(input int c);
    for (int n = 0; n < 20000 && u_far.rxq.size() < c; n++) @(posedge clk_in);
    chk(u_far.rxq.size(), c, "chars heard");
  endtask
  task automatic t_reset;
    bus(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h0, "data reset");
    bus(1'b0, `USPD_LSR_ADDR, 32'h0, q);
    chk(q, 32'h60, "status reset");
    bus(1'b0, 8'h7C, 32'h0, q);
    chk(q, 32'h0, "unmapped read");
    chk(irq_out, 1'b0, "irq reset");
    $display("t_reset done");
  endtask
  task automatic t_rx_plain;
    u_far.send(8'hA5);
    poll(`USPD_LSR_ADDR, `USPD_LSR_DR);
    bus(1'b0, 8'h3C, 32'h0, q);
    chk(q, 32'hA5, "last alias read");
    bus(1'b0, `USPD_LSR_ADDR, 32'h0, q);
    chk(q[0], 1'b0, "ready clears");
    u_far.send(8'h11);
    u_far.send(8'h22);
    poll(`USPD_IST_ADDR, `USPD_EV_OE);
    chk(irq_out, 1'b0, "irq masked");
    bus(1'b1, `USPD_IEN_ADDR, 32'h2, q);
    @(posedge clk_in);
    chk(irq_out, 1'b1, "irq raised");
    bus(1'b0, `USPD_LSR_ADDR, 32'h0, q);
    chk(q[1:0], 2'h3, "overrun flagged");
    bus(1'b0, 8'h20, 32'h0, q);
    chk(q, 32'h22, "newest kept");
    bus(1'b1, `USPD_ICLR_ADDR, 32'h7, q);
    @(posedge clk_in);
    chk(irq_out, 1'b0, "irq cleared");
    $display("t_rx_plain done");
  endtask
  task automatic t_tx_plain;
    u_far.rxq.delete();
    poll(`USPD_LSR_ADDR, `USPD_LSR_TX_HOLDING_EMPTY_FLAG);
    bus(1'b1, 8'h00, 32'h1C3, q);
    poll(`USPD_LSR_ADDR, `USPD_LSR_TX_HOLDING_EMPTY_FLAG);
    bus(1'b1, 8'h04, 32'h5A, q);
    bus(1'b0, `USPD_LSR_ADDR, 32'h0, q);
    chk(q[5], 1'b0, "holding full");
    bus(1'b1, 8'h08, 32'h96, q);
    wait_q(2);
    chk(u_far.rxq[0], 8'hC3, "upper bits ignored");
    chk(u_far.rxq[1], 8'h96, "pending overwritten");
    $display("t_tx_plain done");
  endtask
  task automatic t_fifo;
    bus(1'b1, `USPD_CTRL_ADDR, 32'h1, q);
    u_far.rxq.delete();
    poll(`USPD_LSR_ADDR, `USPD_LSR_TX_HOLDING_EMPTY_FLAG);
    // Shifter takes one, the FIFO the next sixteen, the last is lost
    for (int i = 0; i < 18; i++) bus(1'b1, uspd_addr_t'(4 * (i % 16)), 32'h30 + i, q);
    wait_q(`USPD_FIFO_DEPTH + 1);
    repeat (700) @(posedge clk_in);
    chk(u_far.rxq.size(), `USPD_FIFO_DEPTH + 1, "full write dropped");
    for (int i = 0; i <= 16; i++) chk(u_far.rxq[i], 32'h30 + i, "tx order");
    for (int i = 0; i < 17; i++) u_far.send(8'(8'h50 + i));
    repeat (40) @(posedge clk_in);
    bus(1'b0, `USPD_LSR_ADDR, 32'h0, q);
    chk(q[1:0], 2'h3, "rx full overrun");
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, uspd_addr_t'(4 * i), 32'h0, q);
      chk(q, 32'h50 + i, "rx oldest first");
    end
    bus(1'b0, `USPD_LSR_ADDR, 32'h0, q);
    chk(q[0], 1'b0, "late char lost");
    $display("t_fifo done");
  endtask
  task automatic t_ir;
    bus(1'b1, `USPD_CTRL_ADDR, 32'h2, q);
    ir_mode <= 1'b1;
    u_far.rxq.delete();
    u_far.send(8'h3C);
    poll(`USPD_LSR_ADDR, `USPD_LSR_DR);
    bus(1'b0, 8'h08, 32'h0, q);
    chk(q, 32'h3C, "ir receive");
    bus(1'b1, 8'h08, 32'h96, q);
    wait_q(1);
    chk(u_far.rxq[0], 8'h96, "ir transmit");
    chk(serial_out, 1'b1, "serial idle in ir");
    $display("t_ir done");
  endtask
  // Print counts and verdict, then stop
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    rst_n_in = 1'b0;
    read_in = 1'b0;
    write_in = 1'b0;
    address_in = 8'h00;
    writedata_in = 32'h0;
    byteenable_in = 4'hF;
    baud_tick_in = 1'b0;
    ir_mode = 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset;
    t_rx_plain;
    t_tx_plain;
    t_fifo;
    t_ir;
    complete_run;
  end
  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk_in);
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    complete_run;
  end
endmodule
`default_nettype wire
